// ---- pkg/acc_pkg.sv ----
package acc_pkg;

	// ==========================================================
	// channels and bus
	// ==========================================================
	localparam int NUM_CHAN = 4;
	localparam int ADR_W = 18;
	localparam int IDX_W = 16;

	// ==========================================================
	// register indices, byte address is four times the index
	// ==========================================================
	localparam logic [IDX_W-1:0] IDX_CFG_AB = 16'ha038;
	localparam logic [IDX_W-1:0] IDX_CFG_CD = 16'ha039;
	localparam logic [IDX_W-1:0] IDX_FIRST_DAC_THRESHOLD = 16'ha03a;
	localparam logic [IDX_W-1:0] IDX_SECOND_DAC_THRESHOLD = 16'ha03b;
	localparam logic [IDX_W-1:0] IDX_STATUS = 16'ha03d;

	// ==========================================================
	// reset values and field positions
	// ==========================================================
	localparam logic [7:0] RST_CFG = 8'h00;
	localparam logic [7:0] RST_VTH = 8'h00;
	localparam logic [3:0] RST_FLAGS = 4'h0;
	localparam logic [3:0] RST_FILTER_ON = 4'h0;
	localparam int STATUS_FLAG_LSB = 4;
	localparam int STATUS_LEVEL_LSB = 0;
	localparam int CFG_HI_LSB = 4;
	localparam int CFG_LO_LSB = 0;

	// ==========================================================
	// glitch filter
	// ==========================================================
	localparam int FILTER_CYCLES = 16;
	localparam int FILTER_CNT_W = 4;
	localparam logic [FILTER_CNT_W-1:0] FILTER_LAST =
		FILTER_CNT_W'(FILTER_CYCLES - 1);

	// ==========================================================
	// types
	// ==========================================================
	typedef struct packed {
		logic enable;
		logic threshold_select;
		logic irq_enable;
		logic invert;
	} acc_chan_cfg_type;

	typedef struct packed {
		logic we;
		logic lane0;
		logic [IDX_W-1:0] idx;
		logic [7:0] wdata;
	} acc_bus_req_type;

	typedef enum logic [0:0] {
		ACC_BUS_IDLE = 1'b0,
		ACC_BUS_ACK = 1'b1
	} acc_bus_state_type;

endpackage

// ---- rtl/acc_chan.sv ----
`timescale 1ns/1ps
module acc_chan
	import acc_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic raw_in,
	input wire logic enable_in,
	input wire logic invert_in,
	input wire logic filter_on_in,
	output logic level_out,
	output logic toggle_out
);

	// ==========================================================
	// synchroniser, a change counts once stages two and three agree
	// ==========================================================
	logic [2:0] sync_q;
	logic [2:0] sync_d;
	logic settled_q;
	logic settled_d;
	logic filt_q;
	logic filt_d;
	logic [FILTER_CNT_W-1:0] cnt_q;
	logic [FILTER_CNT_W-1:0] cnt_d;
	logic level_q;
	logic level_d;
	logic toggle_q;
	logic toggle_d;
	logic cand;

	always_comb begin
		sync_d = {sync_q[1:0], raw_in};
		settled_d = settled_q;
		if (sync_q[1] == sync_q[2]) begin
			settled_d = sync_q[2];
		end
		cand = settled_q ^ invert_in;
		filt_d = filt_q;
		cnt_d = '0;
		if (!filter_on_in) begin
			filt_d = cand;
		end else if (cand != filt_q) begin
			// accepted only after a full run of equal samples
			if (cnt_q == FILTER_LAST) begin
				filt_d = cand;
			end else begin
				cnt_d = cnt_q + FILTER_CNT_W'(1);
			end
		end
		level_d = enable_in ? filt_q : 1'b0;
		toggle_d = enable_in && (level_d != level_q);
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sync_q <= 3'h0;
			settled_q <= 1'b0;
			filt_q <= 1'b0;
			cnt_q <= '0;
			level_q <= 1'b0;
			toggle_q <= 1'b0;
		end else begin
			sync_q <= sync_d;
			settled_q <= settled_d;
			filt_q <= filt_d;
			cnt_q <= cnt_d;
			level_q <= level_d;
			toggle_q <= toggle_d;
		end
	end

	assign level_out = level_q;
	assign toggle_out = toggle_q;

endmodule

// ---- rtl/acc_top.sv ----
// How it works
// - Four channels each have an enable bit, and a disabled channel powers down with its other configuration bits held at zero.
// - Comparator A uses the first DAC threshold when its select bit is zero and the second when it is one.
// - Comparators B, C and D use the first DAC threshold when select is zero and the external threshold when it is one.
// - A polarity bit of one inverts the comparator result before any further use, zero passes it unchanged.
// - Only a channel with its interrupt enable set can drive the comparator interrupt request.
// - Software reads each comparator's current level through the status register without any latching.
// - Every comparator level feeds an edge detector where both rising and falling edges are events.
// - The first threshold register holds an 8-bit DAC code from zero volts at 0x00 to full scale at 0xff.
// - A channel's event flag sets when its level toggles while enabled and stays set until software clears it.
// - A disabled comparator's live level reads as low whatever the analog inputs do.
// - With its filter on, a channel accepts a new level only after it has held for 16 clock cycles.
// - The second threshold register uses the same 8-bit code and also drives the DAC voltage output.
`timescale 1ns/1ps
module acc_top
	import acc_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [ADR_W-1:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	input wire logic [NUM_CHAN-1:0] comp_raw_in,
	output logic [NUM_CHAN-1:0] comp_enable_out,
	output logic [NUM_CHAN-1:0] comp_threshold_select_out,
	output logic [7:0] first_dac_threshold_out,
	output logic [7:0] second_dac_threshold_out,
	output logic comp_irq_out
);

	// ==========================================================
	// state
	// ==========================================================
	acc_bus_state_type state_q;
	acc_bus_state_type state_d;
	logic ack_q;
	logic ack_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	acc_bus_req_type req;
	logic wr_now;

	acc_chan_cfg_type [NUM_CHAN-1:0] cfg_q;
	acc_chan_cfg_type [NUM_CHAN-1:0] cfg_d;
	logic [7:0] first_dac_threshold_q;
	logic [7:0] first_dac_threshold_d;
	logic [7:0] second_dac_threshold_q;
	logic [7:0] second_dac_threshold_d;
	logic [NUM_CHAN-1:0] filter_on_q;
	logic [NUM_CHAN-1:0] filter_on_d;
	logic [NUM_CHAN-1:0] flag_q;
	logic [NUM_CHAN-1:0] flag_d;
	logic irq_q;
	logic irq_d;

	logic [NUM_CHAN-1:0] level;
	logic [NUM_CHAN-1:0] toggle;
	logic [NUM_CHAN-1:0] enables;
	logic [NUM_CHAN-1:0] flag_clear;
	logic [7:0] byte_ab;
	logic [7:0] byte_cd;

	// a disabled channel keeps nothing but its cleared enable
	function automatic acc_chan_cfg_type hold_cfg(input logic [3:0] v);
		acc_chan_cfg_type c;
		c = acc_chan_cfg_type'(v);
		if (!c.enable) begin
			c = acc_chan_cfg_type'(4'h0);
		end
		return c;
	endfunction

	// ==========================================================
	// per-channel front end
	// ==========================================================
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CHAN; gi = gi + 1) begin : g_chan
			assign enables[gi] = cfg_q[gi].enable;
			acc_chan u_chan (
				.clk_in(clk_in),
				.reset_n_in(reset_n_in),
				.raw_in(comp_raw_in[gi]),
				.enable_in(cfg_q[gi].enable),
				.invert_in(cfg_q[gi].invert),
				.filter_on_in(filter_on_q[gi]),
				.level_out(level[gi]),
				.toggle_out(toggle[gi])
			);
		end
	endgenerate

	assign byte_ab = {cfg_q[0], cfg_q[1]};
	assign byte_cd = {cfg_q[2], cfg_q[3]};

	// ==========================================================
	// wishbone slave, answer one cycle after the request is seen
	// ==========================================================
	assign req.we = wb_we_in;
	assign req.lane0 = wb_sel_in[0];
	assign req.idx = wb_adr_in[ADR_W-1:2];
	assign req.wdata = wb_dat_in[7:0];

	// writes land on the edge where the master samples ack
	assign wr_now = (state_q == ACC_BUS_ACK) && wb_cyc_in && wb_stb_in &&
		req.we && req.lane0;

	always_comb begin
		state_d = state_q;
		ack_d = 1'b0;
		rdata_d = rdata_q;
		case (state_q)
			ACC_BUS_IDLE: begin
				if (wb_cyc_in && wb_stb_in) begin
					state_d = ACC_BUS_ACK;
					ack_d = 1'b1;
					case (req.idx)
						IDX_CFG_AB: rdata_d = byte_ab;
						IDX_CFG_CD: rdata_d = byte_cd;
						IDX_FIRST_DAC_THRESHOLD: rdata_d = first_dac_threshold_q;
						IDX_SECOND_DAC_THRESHOLD: rdata_d = second_dac_threshold_q;
						IDX_STATUS: rdata_d = {flag_q, level};
						default: rdata_d = 8'h00;
					endcase
				end
			end
			ACC_BUS_ACK: begin
				state_d = ACC_BUS_IDLE;
			end
			default: begin
				state_d = ACC_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_q <= ACC_BUS_IDLE;
			ack_q <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			state_q <= state_d;
			ack_q <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	// ==========================================================
	// registers and event flags
	// ==========================================================
	always_comb begin
		cfg_d = cfg_q;
		first_dac_threshold_d = first_dac_threshold_q;
		second_dac_threshold_d = second_dac_threshold_q;
		filter_on_d = filter_on_q;
		flag_clear = 4'h0;
		if (wr_now) begin
			case (req.idx)
				IDX_CFG_AB: begin
					cfg_d[0] = hold_cfg(req.wdata[CFG_HI_LSB +: 4]);
					cfg_d[1] = hold_cfg(req.wdata[CFG_LO_LSB +: 4]);
				end
				IDX_CFG_CD: begin
					cfg_d[2] = hold_cfg(req.wdata[CFG_HI_LSB +: 4]);
					cfg_d[3] = hold_cfg(req.wdata[CFG_LO_LSB +: 4]);
				end
				IDX_FIRST_DAC_THRESHOLD: first_dac_threshold_d = req.wdata;
				IDX_SECOND_DAC_THRESHOLD: second_dac_threshold_d = req.wdata;
				IDX_STATUS: begin
					filter_on_d = req.wdata[STATUS_LEVEL_LSB +: NUM_CHAN];
					flag_clear = req.wdata[STATUS_FLAG_LSB +: NUM_CHAN];
				end
				default: begin
					cfg_d = cfg_q;
				end
			endcase
		end
		// filters of powered-down channels fall back to off
		filter_on_d = filter_on_d & {cfg_d[3].enable, cfg_d[2].enable,
			cfg_d[1].enable, cfg_d[0].enable};
		// write one to clear, a same-cycle event wins over the clear
		flag_d = (flag_q & ~flag_clear) | (toggle & enables);
		irq_d = |(flag_q & {cfg_q[3].irq_enable, cfg_q[2].irq_enable,
			cfg_q[1].irq_enable, cfg_q[0].irq_enable});
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cfg_q[0] <= acc_chan_cfg_type'(RST_CFG[CFG_HI_LSB +: 4]);
			cfg_q[1] <= acc_chan_cfg_type'(RST_CFG[CFG_LO_LSB +: 4]);
			cfg_q[2] <= acc_chan_cfg_type'(RST_CFG[CFG_HI_LSB +: 4]);
			cfg_q[3] <= acc_chan_cfg_type'(RST_CFG[CFG_LO_LSB +: 4]);
			first_dac_threshold_q <= RST_VTH;
			second_dac_threshold_q <= RST_VTH;
			filter_on_q <= RST_FILTER_ON;
			flag_q <= RST_FLAGS;
			irq_q <= 1'b0;
		end else begin
			cfg_q <= cfg_d;
			first_dac_threshold_q <= first_dac_threshold_d;
			second_dac_threshold_q <= second_dac_threshold_d;
			filter_on_q <= filter_on_d;
			flag_q <= flag_d;
			irq_q <= irq_d;
		end
	end

	// ==========================================================
	// outputs, all from flops
	// ==========================================================
	// the filter enables sit under the live levels, so they are write-only
	assign wb_dat_out = {24'h000000, rdata_q};
	assign wb_ack_out = ack_q;
	assign comp_enable_out = enables;
	// A: 0 first DAC, 1 second DAC; B-D: 0 first DAC, 1 external pin
	assign comp_threshold_select_out = {cfg_q[3].threshold_select,
		cfg_q[2].threshold_select, cfg_q[1].threshold_select,
		cfg_q[0].threshold_select};
	assign first_dac_threshold_out = first_dac_threshold_q;
	assign second_dac_threshold_out = second_dac_threshold_q;
	assign comp_irq_out = irq_q;

endmodule

// ---- tb/acc_cmp_model.sv ----
`timescale 1ns/1ps
module acc_cmp_model
(
	input wire logic clk_in,
	input wire logic [3:0] en_in,
	input wire logic [3:0] sel_in,
	input wire logic [7:0] first_dac_threshold_in,
	input wire logic [7:0] second_dac_threshold_in,
	input wire logic [7:0] ext_in,
	input wire logic [3:0][7:0] ain_in,
	output logic [3:0] raw_out
);
	// ======
	// comparator cores
	// ======
	logic [3:0] tog_q = 4'h5;
	logic [7:0] th;
	// powered-down core output is junk, never a steady 0
	always @(posedge clk_in) tog_q <= ~tog_q;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (i == 0)
				th = sel_in[0] ? second_dac_threshold_in : first_dac_threshold_in;
			else
				th = sel_in[i] ? ext_in : first_dac_threshold_in;
			// linear code compare stands in for the dac
			raw_out[i] = en_in[i] ? (ain_in[i] > th) : tog_q[i];
		end
	end
endmodule

// ---- tb/acc_chk.sv ----
`timescale 1ns/1ps
module acc_chk
	import acc_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [ADR_W-1:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	input wire logic [31:0] wb_dat_out,
	input wire logic wb_ack_out,
	input wire logic [NUM_CHAN-1:0] comp_raw_in,
	input wire logic [NUM_CHAN-1:0] comp_enable_out,
	input wire logic [NUM_CHAN-1:0] comp_threshold_select_out,
	input wire logic [7:0] first_dac_threshold_out,
	input wire logic [7:0] second_dac_threshold_out,
	input wire logic comp_irq_out
);
	// ======
	// helpers
	// ======
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	logic [31:0] dat_q;
	always_ff @(posedge clk_in) dat_q <= wb_dat_in;
	sequence s_wr(logic [IDX_W-1:0] i);
		wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out && wb_sel_in[0]
			&& wb_adr_in[ADR_W-1:2] == i;
	endsequence
	sequence s_rd_stat;
		wb_ack_out && !wb_we_in && wb_adr_in[ADR_W-1:2] == IDX_STATUS;
	endsequence
	// ======
	// assertions
	// ======
	AST_ACK_PULSE: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack held too long");
	AST_ACK_TIME: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out
		|=> wb_ack_out) else $error("ack late");
	AST_RD_UPPER: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h0)
		else $error("upper read bits set");
	AST_EN_AB: assert property (s_wr(IDX_CFG_AB) |=>
		comp_enable_out[1:0] == {dat_q[3], dat_q[7]})
		else $error("enable not stored");
	AST_SEL_CD: assert property (s_wr(IDX_CFG_CD) |=>
		comp_threshold_select_out[3:2] ==
		{dat_q[3] & dat_q[2], dat_q[7] & dat_q[6]})
		else $error("select not stored");
	AST_SEL_GATED: assert property (
		(comp_threshold_select_out & ~comp_enable_out) == 4'h0)
		else $error("select kept while disabled");
	AST_FIRST_DAC_THRESHOLD: assert property (s_wr(IDX_FIRST_DAC_THRESHOLD) |=>
		first_dac_threshold_out == dat_q[7:0]) else $error("first_dac_threshold wrong");
	AST_SECOND_DAC_THRESHOLD: assert property (s_wr(IDX_SECOND_DAC_THRESHOLD) |=>
		second_dac_threshold_out == dat_q[7:0]) else $error("second_dac_threshold wrong");
	AST_LIVE_LOW: assert property (s_rd_stat |->
		(wb_dat_out[3:0] & ~comp_enable_out) == 4'h0)
		else $error("disabled level high");
endmodule

// ---- tb/acc_top_tb_top.sv ----
`timescale 1ns/1ps
module acc_top_tb_top
	import acc_pkg::*;
;
	logic clk_in = 0, reset_n_in = 0, cyc = 0, stb = 0, we = 0, ack, irq;
	logic [ADR_W-1:0] adr = '0;
	logic [3:0] sel = 4'h1, raw, en, ts;
	logic [31:0] wdat = '0, rdat, rv;
	logic [7:0] v0, v1, ext = 8'h20;
	logic [3:0][7:0] ain = {8'h30, 8'h30, 8'h30, 8'h80};
	int bad_count = 0, num_checks = 0;
	acc_top DUT(.clk_in(clk_in), .reset_n_in(reset_n_in), .wb_cyc_in(cyc),
		.wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
		.wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
		.comp_raw_in(raw), .comp_enable_out(en),
		.comp_threshold_select_out(ts), .first_dac_threshold_out(v0),
		.second_dac_threshold_out(v1), .comp_irq_out(irq));
	acc_cmp_model u_cmp(.clk_in(clk_in), .en_in(en), .sel_in(ts),
		.first_dac_threshold_in(v0), .second_dac_threshold_in(v1), .ext_in(ext), .ain_in(ain),
		.raw_out(raw));
	// ======
	// shared tasks
	// ======
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [IDX_W-1:0] i,
		input logic [7:0] d);
		@(posedge clk_in);
		{cyc, stb, we} <= {2'b11, w};
		adr <= {i, 2'b00};
		wdat <= {24'h0, d};
		do @(posedge clk_in); while (ack !== 1'b1);
		rv = rdat;
		{cyc, stb} <= 2'b00;
	endtask
	task automatic rc(input logic [IDX_W-1:0] i, input logic [7:0] e);
		bus(1'b0, i, 8'h00);
		chk(rv, {24'h0, e});
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	// ======
	// scenarios
	// ======
	task automatic t_rst();
		chk({20'h0, en, ts, irq, 3'h0}, 32'h0);
		rc(IDX_CFG_AB, 8'h00);
		rc(IDX_CFG_CD, 8'h00);
		rc(IDX_FIRST_DAC_THRESHOLD, 8'h00);
		rc(IDX_SECOND_DAC_THRESHOLD, 8'h00);
		rc(IDX_STATUS, 8'h00);
		$display("test reset done");
	endtask
	task automatic t_dac();
		bus(1'b1, IDX_FIRST_DAC_THRESHOLD, 8'hff);
		rc(IDX_FIRST_DAC_THRESHOLD, 8'hff);
		bus(1'b1, IDX_SECOND_DAC_THRESHOLD, 8'hff);
		// the write lands on the ack edge, so look one edge later
		wt(1);
		chk({v0, v1}, 32'hffff);
		bus(1'b1, 16'h0001, 8'h5a);
		rc(16'h0001, 8'h00);
		bus(1'b1, IDX_CFG_AB, 8'h7f);
		rc(IDX_CFG_AB, 8'h0f);
		chk({28'h0, ts}, 32'h2);
		$display("test registers done");
	endtask
	task automatic t_live();
		bus(1'b1, IDX_FIRST_DAC_THRESHOLD, 8'h40);
		bus(1'b1, IDX_SECOND_DAC_THRESHOLD, 8'hc0);
		bus(1'b1, IDX_CFG_AB, 8'he9);
		bus(1'b1, IDX_CFG_CD, 8'hc0);
		wt(400);
		bus(1'b1, IDX_STATUS, 8'hf0);
		rc(IDX_STATUS, 8'h06);
		chk(irq, 1'b0);
		ain[0] <= 8'hd0;
		wt(10);
		rc(IDX_STATUS, 8'h17);
		chk(irq, 1'b1);
		ain[2] <= 8'h10;
		wt(10);
		bus(1'b1, IDX_STATUS, 8'h10);
		rc(IDX_STATUS, 8'h43);
		chk(irq, 1'b0);
		ain[0] <= 8'h80;
		wt(10);
		rc(IDX_STATUS, 8'h52);
		chk(irq, 1'b1);
		$display("test live levels done");
	endtask
	task automatic t_filt();
		bus(1'b1, IDX_STATUS, 8'hf1);
		ain[0] <= 8'hd0;
		wt(10);
		ain[0] <= 8'h80;
		wt(30);
		rc(IDX_STATUS, 8'h02);
		ain[0] <= 8'hd0;
		wt(10);
		rc(IDX_STATUS, 8'h02);
		wt(20);
		rc(IDX_STATUS, 8'h13);
		bus(1'b1, IDX_SECOND_DAC_THRESHOLD, 8'h00);
		rc(IDX_SECOND_DAC_THRESHOLD, 8'h00);
		$display("test filter done");
	endtask
	// ======
	// run
	// ======
	initial forever #25 clk_in = ~clk_in;
	initial begin
		wt(5000);
		bad_count++;
		give_verdict();
	end
	initial begin
		wt(5);
		reset_n_in <= 1'b1;
		t_rst();
		t_dac();
		t_live();
		t_filt();
		give_verdict();
	end
endmodule
bind acc_top acc_chk u_chk(.clk_in(clk_in), .reset_n_in(reset_n_in),
	.wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
	.wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
	.wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
	.comp_raw_in(comp_raw_in), .comp_enable_out(comp_enable_out),
	.comp_threshold_select_out(comp_threshold_select_out),
	.first_dac_threshold_out(first_dac_threshold_out),
	.second_dac_threshold_out(second_dac_threshold_out),
	.comp_irq_out(comp_irq_out));
